// File: rtl/csp_pin_if.sv
// Bundle of synchronised link pin levels and their edges.
// Driven by the synchroniser, read by the port core, same clock.
`timescale 1ns/1ps
interface csp_pin_if;
	logic en;
	logic [csp_pkg::NPIN-1:0] lvl;
	logic [csp_pkg::NPIN-1:0] rise;
	logic [csp_pkg::NPIN-1:0] fall;
	modport src (input en, output lvl, output rise, output fall);
	modport dst (output en, input lvl, input rise, input fall);
endinterface

// File: rtl/csp_pkg.sv
// Constants for the codec serial port: register map, control fields,
// pin indices and timing counts.
// Assumes a 20 MHz system clock and 32-bit AXI4-Lite register access.
package csp_pkg;

	// Register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_TXW = 4'h4;
	localparam logic [3:0] OFF_RXW = 4'h8;
	localparam logic [3:0] OFF_PWR = 4'hC;

	// Control register fields
	localparam int RX_RESET_N_BIT = 7;
	localparam int TX_RESET_N_BIT = 6;
	localparam int TX_SYNC_SRC_BIT = 5;
	localparam int TX_CLOCK_SRC_BIT = 4;
	localparam int BURST_BIT = 3;
	localparam int WORD_SIZE_BIT = 2;
	localparam int LOOPBACK_BIT = 1;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h00FE;

	// Power register field
	localparam int CLK_STOP_BIT = 0;

	// Word lengths as last-bit counts
	localparam logic [4:0] LAST_LONG = 5'h0F;
	localparam logic [4:0] LAST_SHORT = 5'h07;

	// Synchronised pin indices
	localparam int PIN_TXC = 0;
	localparam int PIN_TXF = 1;
	localparam int PIN_RXC = 2;
	localparam int PIN_RXF = 3;
	localparam int PIN_RXD = 4;
	localparam int NPIN = 5;

	// Internal bit clock: half period in ns and in system cycles
	localparam int SYS_CLK_NS = 50;
	localparam int INT_HALF_NS = 200;
	localparam logic [3:0] INT_HALF_CYC = 4'((INT_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Shift engine states
	typedef enum logic {LS_IDLE, LS_SHIFT} csp_link_state_t;

endpackage

// File: rtl/csp_sync.sv
// Two-flop synchroniser with edge detection for the link pins.
// Assumes pins are asynchronous to ref_clk_i; en low freezes all stages.
`timescale 1ns/1ps
module csp_sync (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Raw pins
	input wire logic [csp_pkg::NPIN-1:0] raw_i,
	// Synchronised side
	csp_pin_if.src pins
);
	logic [csp_pkg::NPIN-1:0] meta_reg;
	logic [csp_pkg::NPIN-1:0] sync_reg;
	logic [csp_pkg::NPIN-1:0] prev_reg;

	genvar g;
	generate
		for (g = 0; g < csp_pkg::NPIN; g++) begin : g_pin
			// Edges only from second and third stage, never the first
			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					meta_reg[g] <= 1'h0;
					sync_reg[g] <= 1'h0;
					prev_reg[g] <= 1'h0;
				end else if (pins.en) begin
					meta_reg[g] <= raw_i[g];
					sync_reg[g] <= meta_reg[g];
					prev_reg[g] <= sync_reg[g];
				end
			end
			assign pins.lvl[g] = sync_reg[g];
			assign pins.rise[g] = pins.en & sync_reg[g] & ~prev_reg[g];
			assign pins.fall[g] = pins.en & ~sync_reg[g] & prev_reg[g];
		end
	endgenerate
endmodule // csp_sync

// File: rtl/csp_top.sv
// Full-duplex codec serial port with AXI4-Lite registers.
// Assumes link pins come from outside the 20 MHz domain and are slow.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module csp_top (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Transmit link pins
	input wire logic tx_bit_clock_i,
	output logic tx_bit_clock_o,
	output logic tx_bit_clock_oe_o,
	input wire logic tx_frame_sync_i,
	output logic tx_frame_sync_o,
	output logic tx_frame_sync_oe_o,
	output logic tx_serial_line_o,
	output logic tx_serial_line_oe_o,
	// Receive link pins
	input wire logic rx_bit_clock_i,
	input wire logic rx_frame_sync_i,
	input wire logic rx_serial_line_i
);
	// Register state
	logic [15:0] ctrl_reg;
	logic [15:0] txw_reg;
	logic [15:0] rxw_reg;
	logic clk_stop_reg;
	logic xrdy_reg;
	logic rrdy_reg;
	// Bus state
	logic aw_have_reg, w_have_reg;
	logic [3:0] aw_addr_reg;
	logic [15:0] w_data_reg;
	logic [1:0] w_strb_reg;
	// Link state
	csp_pkg::csp_link_state_t tx_state_reg, rx_state_reg;
	logic [4:0] tx_cnt_reg, rx_cnt_reg;
	logic [15:0] tx_sh_reg, rx_sh_reg;
	logic tx_chain_reg, rx_chain_reg;
	logic [3:0] div_cnt_reg;
	logic int_clk_reg, int_fs_reg;

	csp_pin_if pins ();

	csp_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.raw_i({rx_serial_line_i, rx_frame_sync_i, rx_bit_clock_i,
			tx_frame_sync_i, tx_bit_clock_i}),
		.pins(pins)
	);

	// Register decode, shared by write and read paths
	function automatic logic [2:0] reg_hit(input logic [3:0] a);
		reg_hit = {a == csp_pkg::OFF_PWR, a == csp_pkg::OFF_RXW, a == csp_pkg::OFF_TXW};
	endfunction

	// Byte-lane merge for the 16-bit registers
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		lane_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	// Control fields
	wire rx_run = ctrl_reg[csp_pkg::RX_RESET_N_BIT];
	wire tx_run = ctrl_reg[csp_pkg::TX_RESET_N_BIT];
	wire sync_src = ctrl_reg[csp_pkg::TX_SYNC_SRC_BIT];
	wire clk_src = ctrl_reg[csp_pkg::TX_CLOCK_SRC_BIT];
	wire burst = ctrl_reg[csp_pkg::BURST_BIT];
	wire short_word = ctrl_reg[csp_pkg::WORD_SIZE_BIT];
	wire loop = ctrl_reg[csp_pkg::LOOPBACK_BIT];
	wire [4:0] last_cnt = short_word ? csp_pkg::LAST_SHORT : csp_pkg::LAST_LONG;

	// Clocks stop only while both halves sit in reset
	wire clk_stop_now = clk_stop_reg & ~rx_run & ~tx_run;
	assign pins.en = ~clk_stop_now;

	// Write channel decode
	wire wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
	wire [2:0] wr_hit = reg_hit(aw_addr_reg);
	wire wr_ctrl = wr_fire & (aw_addr_reg == csp_pkg::OFF_CTRL);
	wire wr_txw = wr_fire & wr_hit[0];
	wire wr_pwr = wr_fire & wr_hit[2];
	wire wr_ok = (aw_addr_reg == csp_pkg::OFF_CTRL) | (|wr_hit);

	// Write address and data taken independently, answered after both
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_have_reg <= 1'h0;
			w_have_reg <= 1'h0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 16'h0000;
			w_strb_reg <= 2'h0;
			s_axi_bvalid_o <= 1'h0;
			s_axi_bresp_o <= csp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i & s_axi_awready_o) begin
				aw_have_reg <= 1'h1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & s_axi_wready_o) begin
				w_have_reg <= 1'h1;
				w_data_reg <= s_axi_wdata_i[15:0];
				w_strb_reg <= s_axi_wstrb_i[1:0];
			end
			if (wr_fire) begin
				aw_have_reg <= 1'h0;
				w_have_reg <= 1'h0;
				s_axi_bvalid_o <= 1'h1;
				s_axi_bresp_o <= wr_ok ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'h0;
			end
		end
	end
	// Ready flops: open only when the slot is empty
	logic aw_ready_reg, w_ready_reg;
	assign s_axi_awready_o = aw_ready_reg;
	assign s_axi_wready_o = w_ready_reg;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_ready_reg <= 1'h0;
			w_ready_reg <= 1'h0;
		end else begin
			aw_ready_reg <= ~aw_have_reg & ~(s_axi_awvalid_i & aw_ready_reg) & ~wr_fire;
			w_ready_reg <= ~w_have_reg & ~(s_axi_wvalid_i & w_ready_reg) & ~wr_fire;
		end
	end

	// Software-visible configuration; the control and power words reconfigure
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_reg <= csp_pkg::CTRL_RESET;
			txw_reg <= 16'h0000;
			clk_stop_reg <= 1'h0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= lane_merge(ctrl_reg, w_data_reg, w_strb_reg) & csp_pkg::CTRL_WMASK;
			if (wr_txw)
				txw_reg <= lane_merge(txw_reg, w_data_reg, w_strb_reg);
			if (wr_pwr & w_strb_reg[0])
				clk_stop_reg <= w_data_reg[csp_pkg::CLK_STOP_BIT];
		end
	end

	// Read path: one cycle to take the address, one to answer
	wire [2:0] rd_hit = reg_hit(s_axi_araddr_i);
	wire rd_ctrl = s_axi_araddr_i == csp_pkg::OFF_CTRL;
	wire rd_fire = s_axi_arvalid_i & s_axi_arready_o;
	wire rd_rxw = rd_fire & rd_hit[1];
	wire [15:0] ctrl_view = {4'h0, xrdy_reg, rrdy_reg, pins.lvl[csp_pkg::PIN_TXC],
		pins.lvl[csp_pkg::PIN_RXC], ctrl_reg[7:1], 1'h0};
	wire [15:0] rd_val = rd_ctrl ? ctrl_view :
		rd_hit[0] ? txw_reg :
		rd_hit[1] ? rxw_reg :
		rd_hit[2] ? {15'h0000, clk_stop_reg} : 16'h0000;
	wire rd_ok = rd_ctrl | (|rd_hit);
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'h0;
			s_axi_rvalid_o <= 1'h0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= csp_pkg::RESP_OKAY;
		end else begin
			s_axi_arready_o <= s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
			if (rd_fire) begin
				s_axi_rvalid_o <= 1'h1;
				s_axi_rdata_o <= {16'h0000, rd_val};
				s_axi_rresp_o <= rd_ok ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'h0;
			end
		end
	end

	// Internal bit clock divider, used only when the clock source bit is set
	wire div_tick = clk_src & ~clk_stop_now & (div_cnt_reg == csp_pkg::INT_HALF_CYC - 4'h1);
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_cnt_reg <= 4'h0;
			int_clk_reg <= 1'h0;
		end else if (!clk_src) begin
			div_cnt_reg <= 4'h0;
		end else if (!clk_stop_now) begin
			div_cnt_reg <= div_tick ? 4'h0 : div_cnt_reg + 4'h1;
			if (div_tick)
				int_clk_reg <= ~int_clk_reg;
		end
	end

	// Transmit clock and sync select: external pins unless the mode bits say otherwise
	wire txc_rise = clk_src ? (div_tick & ~int_clk_reg) : pins.rise[csp_pkg::PIN_TXC];
	wire txc_fall = clk_src ? (div_tick & int_clk_reg) : pins.fall[csp_pkg::PIN_TXC];
	wire tx_fs = sync_src ? int_fs_reg : pins.lvl[csp_pkg::PIN_TXF];

	// Transmit engine; a word starts on a sync, or back to back in continuous mode
	wire tx_last = (tx_state_reg == csp_pkg::LS_SHIFT) & (tx_cnt_reg == 5'h00);
	wire tx_free = (tx_state_reg == csp_pkg::LS_IDLE) | tx_last;
	wire tx_start = tx_run & txc_rise & tx_free & (tx_fs | (~burst & tx_chain_reg));
	wire [15:0] tx_load = short_word ? {txw_reg[7:0], 8'h00} : txw_reg;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_state_reg <= csp_pkg::LS_IDLE;
			tx_cnt_reg <= 5'h00;
			tx_sh_reg <= 16'h0000;
			tx_chain_reg <= 1'h0;
		end else if (!tx_run) begin
			tx_state_reg <= csp_pkg::LS_IDLE;
			tx_chain_reg <= 1'h0;
		end else if (tx_start) begin
			tx_state_reg <= csp_pkg::LS_SHIFT;
			tx_cnt_reg <= last_cnt;
			tx_sh_reg <= tx_load;
			tx_chain_reg <= 1'h1;
		end else if (txc_rise & tx_last) begin
			tx_state_reg <= csp_pkg::LS_IDLE;
		end else if (txc_rise & (tx_state_reg == csp_pkg::LS_SHIFT)) begin
			tx_cnt_reg <= tx_cnt_reg - 5'h01;
			tx_sh_reg <= {tx_sh_reg[14:0], 1'h0};
		end
	end
	// Data pin driven only while a word is on the line
	assign tx_serial_line_o = tx_sh_reg[15];
	assign tx_serial_line_oe_o = tx_state_reg == csp_pkg::LS_SHIFT;

	// Internal frame sync: raised on the falling edge before a pending word
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			int_fs_reg <= 1'h0;
		else if (txc_fall)
			int_fs_reg <= sync_src & tx_run & ~xrdy_reg & tx_free;
	end
	// Pin directions follow the mode bits, which reset to inputs
	assign tx_frame_sync_o = int_fs_reg;
	assign tx_frame_sync_oe_o = sync_src;
	assign tx_bit_clock_o = int_clk_reg;
	assign tx_bit_clock_oe_o = clk_src;

	// Transmit-ready: load sets it, a data write clears it; set wins
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			xrdy_reg <= 1'h1;
		else if (tx_start)
			xrdy_reg <= 1'h1;
		else if (wr_txw)
			xrdy_reg <= 1'h0;
	end

	// Receive sources; loopback ties the receiver to the transmit side
	wire rxc_fall = loop ? txc_fall : pins.fall[csp_pkg::PIN_RXC];
	wire rx_fs = loop ? tx_fs : pins.lvl[csp_pkg::PIN_RXF];
	wire rx_d = loop ? tx_serial_line_o : pins.lvl[csp_pkg::PIN_RXD];
	wire rx_busy = rx_state_reg == csp_pkg::LS_SHIFT;
	wire rx_start = rx_run & rxc_fall & ~rx_busy & (rx_fs | (~burst & rx_chain_reg));
	wire rx_done = rx_run & rxc_fall & rx_busy & (rx_cnt_reg == 5'h01);
	wire [15:0] rx_sh_next = {rx_sh_reg[14:0], rx_d};

	// Receive engine: first bit sampled on the sync edge, MSB first
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_state_reg <= csp_pkg::LS_IDLE;
			rx_cnt_reg <= 5'h00;
			rx_sh_reg <= 16'h0000;
			rx_chain_reg <= 1'h0;
			rxw_reg <= 16'h0000;
		end else if (!rx_run) begin
			rx_state_reg <= csp_pkg::LS_IDLE;
			rx_chain_reg <= 1'h0;
		end else if (rx_start) begin
			rx_state_reg <= csp_pkg::LS_SHIFT;
			rx_cnt_reg <= last_cnt;
			rx_sh_reg <= rx_sh_next;
		end else if (rx_done) begin
			rx_state_reg <= csp_pkg::LS_IDLE;
			rx_chain_reg <= 1'h1;
			rxw_reg <= short_word ? {8'h00, rx_sh_next[7:0]} : rx_sh_next;
		end else if (rxc_fall & rx_busy) begin
			rx_cnt_reg <= rx_cnt_reg - 5'h01;
			rx_sh_reg <= rx_sh_next;
		end
	end

	// Receive-ready: a finished word sets it, reading the word clears it; set wins
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rrdy_reg <= 1'h0;
		else if (rx_done)
			rrdy_reg <= 1'h1;
		else if (rd_rxw)
			rrdy_reg <= 1'h0;
	end

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	idle_when_reset_a: assert property (!tx_run |=> !tx_serial_line_oe_o)
		else $error("data line driven while transmitter in reset");
	ext_sync_input_a: assert property (!sync_src |-> !tx_frame_sync_oe_o
		&& tx_fs == pins.lvl[csp_pkg::PIN_TXF])
		else $error("frame sync driven in external sync mode");
	ext_clock_a: assert property (!clk_src |-> !tx_bit_clock_oe_o
		&& txc_rise == pins.rise[csp_pkg::PIN_TXC])
		else $error("transmit clock not from pin");
	long_word_a: assert property (tx_start && !short_word |=> tx_cnt_reg == 5'h0F)
		else $error("transmit word length not sixteen");
	burst_sync_a: assert property (rx_start && burst |-> rx_fs)
		else $error("burst receive started without sync");
	tx_msb_a: assert property (tx_start |=> tx_serial_line_oe_o
		&& tx_serial_line_o == $past(tx_load[15]))
		else $error("first bit is not the word msb");
	rx_ready_a: assert property (rx_done |=> rrdy_reg && rxw_reg[0] == $past(rx_d))
		else $error("received word not posted");
	ctrl_write_a: assert property (wr_ctrl && w_strb_reg[0] |=>
		ctrl_reg[7:1] == $past(w_data_reg[7:1]))
		else $error("control write not stored");
	low_power_a: assert property (clk_stop_now |-> !txc_rise && !rxc_fall)
		else $error("link edges seen while clocks stopped");
	write_resp_a: assert property (wr_fire |=> s_axi_bvalid_o)
		else $error("write response not raised");
	bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("write response dropped");

	word_rx_c: cover property (rx_done && !short_word);
	chain_tx_c: cover property (tx_start && !burst && tx_chain_reg);
	rxw_read_c: cover property (rd_rxw && rrdy_reg);
endmodule // csp_top

// File: test/codec_serial_port_link_test.sv
// Self-checking bench for the codec serial port over AXI4-Lite.
// Assumes the codec model supplies bit clock and frame sync to both paths.
`timescale 1ns/1ps
module codec_serial_port_link_test;
	localparam logic [7:0] CODEC_DEF = 8'h3C; // Arbitrary codec default
	logic ref_clk_i, resetn_i;
	logic [3:0] s_axi_awaddr_i, s_axi_wstrb_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic tx_bit_clock_o, tx_bit_clock_oe_o, tx_frame_sync_o, tx_frame_sync_oe_o;
	logic tx_serial_line_o, tx_serial_line_oe_o, lk_clk, lk_fs, lk_dat;
	logic [15:0] w, s, got;
	logic [15:0] tbl_tw [0:3] = '{16'h8003, 16'h01A5, 16'h7FFF, 16'h2100};
	int n_fail = 0, num_checks = 0, cyc = 0, oe_cnt = 0, fs_cnt = 0, ck_cnt = 0;

	csp_top i_csp_top (.ref_clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.tx_bit_clock_i(lk_clk), .tx_bit_clock_o, .tx_bit_clock_oe_o, .tx_frame_sync_i(lk_fs),
		.tx_frame_sync_o, .tx_frame_sync_oe_o, .tx_serial_line_o, .tx_serial_line_oe_o,
		.rx_bit_clock_i(lk_clk), .rx_frame_sync_i(lk_fs), .rx_serial_line_i(lk_dat));
	csp_codec_model #(.DEF(CODEC_DEF)) i_csp_codec_model (.bit_clock_o(lk_clk),
		.frame_sync_o(lk_fs), .serial_o(lk_dat), .serial_i(tx_serial_line_o),
		.serial_oe_i(tx_serial_line_oe_o));

	// System clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// Watchdog and transmit enable cycle count
	always @(posedge ref_clk_i) begin
		cyc++;
		if (tx_serial_line_oe_o === 1'b1) oe_cnt++;
		if (tx_frame_sync_o === 1'b1 && tx_frame_sync_oe_o === 1'b1) fs_cnt++;
		if (tx_bit_clock_o === 1'b1 && tx_bit_clock_oe_o === 1'b1) ck_cnt++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {16'h0000, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready_o === 1'b1 && s_axi_awvalid_i) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1 && s_axi_wvalid_i) s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		rs = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	// Read: rready held until the data beat is sampled
	task automatic axi_rd(input logic [3:0] a);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		rd = s_axi_rdata_o;
		rs = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	// Load a transmit word, then let the codec run one word
	task automatic frame(input logic [15:0] tw, input logic [15:0] sv, input logic sync);
		axi_wr(csp_pkg::OFF_TXW, tw);
		@(posedge ref_clk_i);
		oe_cnt = 0;
		i_csp_codec_model.xfer(sv, sync, got);
		repeat (4) @(posedge ref_clk_i);
	endtask

	// Codec answer: secondary intervals return zeros and register data
	function automatic logic [15:0] exp_rx(input int i, input logic [15:0] sv);
		if (i == 7) return {8'h00, CODEC_DEF};
		if (i == 9) return 16'h00A5;
		return sv;
	endfunction

	// Main sequence
	initial begin
		resetn_i = 1'b0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		s_axi_wstrb_i = 4'hF;
		void'($urandom(32'h5fe6));
		repeat (8) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		check({tx_bit_clock_oe_o, tx_frame_sync_oe_o, tx_serial_line_oe_o}, 0);
		axi_rd(csp_pkg::OFF_CTRL);
		check(rd & 32'h00FF, 0);
		for (int b = 1; b < 6; b++) begin
			axi_wr(csp_pkg::OFF_CTRL, 16'(1 << b));
			axi_rd(csp_pkg::OFF_CTRL);
			check(rd & 32'h00FF, 32'(1 << b));
			check({tx_bit_clock_oe_o, tx_frame_sync_oe_o}, {b == 4, b == 5});
		end
		w = 16'($urandom) | 16'h0001;
		axi_wr(csp_pkg::OFF_CTRL, w & 16'h003F);
		axi_rd(csp_pkg::OFF_CTRL);
		check(rd & 32'h00FF, 32'(w & 16'h003E));
		// Unmapped place and clock stop register
		axi_wr(4'h2, 16'hFFFF);
		check(rs, csp_pkg::RESP_SLVERR);
		axi_rd(4'h2);
		check(rd, 0);
		check(rs, csp_pkg::RESP_SLVERR);
		axi_wr(csp_pkg::OFF_PWR, 16'h0001);
		axi_rd(csp_pkg::OFF_PWR);
		check(rd, 1);
		axi_wr(csp_pkg::OFF_PWR, 16'h0000);
		// Port held in reset ignores a frame sync
		axi_wr(csp_pkg::OFF_CTRL, 16'h0008);
		frame(16'hFFFF, 16'h1234, 1'b1);
		check(oe_cnt, 0);
		axi_rd(csp_pkg::OFF_CTRL);
		check(rd & 32'h0400, 0);
		// Codec held in reset while the port is reset and configured
		i_csp_codec_model.ctl_write(16'h0000);
		axi_wr(csp_pkg::OFF_CTRL, 16'h0008);
		axi_wr(csp_pkg::OFF_CTRL, 16'h00C8);
		repeat (8) @(posedge ref_clk_i);
		i_csp_codec_model.ctl_write(16'h8000);
		// Random samples, then codec register write and read back
		for (int i = 0; i < 10; i++) begin
			w = (i < 6) ? {14'($urandom), 2'b00} : tbl_tw[i - 6];
			s = {14'($urandom), 2'b00};
			frame(w, s, 1'b1);
			check(oe_cnt, 128);
			check(got, w);
			axi_rd(csp_pkg::OFF_CTRL);
			check(rd & 32'h0C00, 32'h0C00);
			axi_rd(csp_pkg::OFF_RXW);
			check(rd, exp_rx(i, s));
			axi_rd(csp_pkg::OFF_CTRL);
			check(rd & 32'h0400, 0);
		end
		// Burst mode: no sync, no word
		frame(16'h5555, 16'h0000, 1'b0);
		check(oe_cnt, 0);
		// Internal clock and sync, 8-bit word, receiver looped back
		axi_wr(csp_pkg::OFF_CTRL, 16'h003E);
		w = 16'($urandom);
		axi_wr(csp_pkg::OFF_TXW, w);
		axi_wr(csp_pkg::OFF_CTRL, 16'h00FE);
		#1;
		oe_cnt = 0;
		fs_cnt = 0;
		ck_cnt = 0;
		repeat (160) @(posedge ref_clk_i);
		#1;
		check(ck_cnt, 80);
		check(fs_cnt, 2 * csp_pkg::INT_HALF_CYC);
		check(oe_cnt, 16 * csp_pkg::INT_HALF_CYC);
		axi_rd(csp_pkg::OFF_RXW);
		check(rd, {24'h000000, w[7:0]});
		end_of_test();
	end
endmodule // codec_serial_port_link_test

// File: test/csp_codec_model.sv
// Behavioural codec on the far side of the serial link.
// Assumes the bench calls xfer once per word; the clock idles low between words.
`timescale 1ns/1ps
module csp_codec_model #(
	parameter logic [7:0] DEF = 8'h00
) (
	// Link pins toward the port
	output logic bit_clock_o,
	output logic frame_sync_o,
	output logic serial_o,
	// Port transmit line and its enable
	input wire logic serial_i,
	input wire logic serial_oe_i
);
	logic [7:0] regs [0:8];
	logic [4:0] sel;
	logic second;
	logic in_reset;

	// Idle pins, default register contents
	initial begin
		bit_clock_o = 1'b0;
		frame_sync_o = 1'b0;
		serial_o = 1'b0;
		sel = 5'h00;
		second = 1'b0;
		in_reset = 1'b0;
		foreach (regs[r]) regs[r] = DEF;
	end

	// Target/control port: bit 15 low holds the codec, high lets it go with defaults
	task automatic ctl_write(input logic [15:0] v);
		if (!v[15]) begin
			in_reset = 1'b1;
		end else if (in_reset) begin
			in_reset = 1'b0;
			second = 1'b0;
			sel = 5'h00;
			foreach (regs[r]) regs[r] = DEF;
		end
	endtask

	// One word each way; an undriven port line reads as zero
	task automatic xfer(input logic [15:0] samp, input logic sync, output logic [15:0] got);
		logic [15:0] tx;
		tx = second ? {8'h00, (sel < 9) ? regs[sel] : 8'h00} : samp;
		got = 16'h0000;
		#37;
		frame_sync_o = sync;
		#100;
		for (int k = 0; k < 17; k++) begin
			bit_clock_o = 1'b1;
			serial_o = (k < 16) ? tx[15 - k] : ~serial_o;
			#200;
			bit_clock_o = 1'b0;
			#100;
			frame_sync_o = 1'b0;
			#90;
			if (k < 16) got[15 - k] = serial_i & serial_oe_i;
			#10;
		end
		// Secondary word: phase, read flag (1 reads), address, data
		if (second) begin
			sel = got[12:8];
			if (!got[13] && got[12:8] < 9) regs[got[12:8]] = got[7:0];
		end
		second = !second && got[1:0] == 2'b11;
	endtask
endmodule // csp_codec_model
